// >>> src/dpr_ram_port.sv
// One port of a synchronous dual-port RAM: burst counter, lane matching,
// counter readback and flow-through or pipelined outputs.
// Assumes the host keeps its own timing duties; memory contents are not reset.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dpr_ram_port #(
  parameter int AW = dpr_pkg::ADDR_W
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  dpr_port_if.dev            p,
  output logic      [AW-1:0] counter_addr,
  output logic      [1:0]    counter_lane
);
  localparam int DW = dpr_pkg::DATA_W;

  logic [DW-1:0]      mem [2**AW];
  logic [AW-1:0]      cnt_q;
  logic [1:0]         lane_q;
  logic [AW-1:0]      acc_a;
  logic [1:0]         acc_l;
  logic [1:0]         first_l;
  logic [1:0]         last_l;
  dpr_pkg::dpr_width_e wid;
  logic               sel;
  logic               ld;
  logic               inc;
  logic               clr;
  logic               rbk;
  logic [1:0]         rbph_q;
  logic [AW-1:0]      ra_q;
  logic [1:0]         rl_q;
  dpr_pkg::dpr_width_e wid_q;
  logic               rd_q;
  logic               rbk_q;
  logic [DW-1:0]      rbv_q;
  logic [DW-1:0]      rbv;
  logic [DW-1:0]      ft_word;
  logic               ft_drv;
  logic [DW-1:0]      pipe_q;
  logic               pipe_drv_q;
  logic               drv;

  assign sel = !p.chip_sel_n;
  assign clr = !p.count_clear_n;
  assign ld  = !p.address_strobe_load_n && !p.count_advance_enable_n;
  assign inc = p.address_strobe_load_n && !p.count_advance_enable_n;
  // Strobe alone with read selected shows the counter
  assign rbk = sel && p.write_n && !p.address_strobe_load_n
               && p.count_advance_enable_n && !clr;

  assign wid = dpr_pkg::width_decode(p.width_match_select,
                                     p.lane_size_select);
  assign first_l = dpr_pkg::lane_at(wid, p.lane_order_select, 4'h0);
  assign last_l  = dpr_pkg::lane_at(wid, p.lane_order_select,
                                    4'(dpr_pkg::lane_count(wid) - 3'h1));

  // Address used by the access in this cycle
  always_comb begin
    acc_a = cnt_q;
    acc_l = lane_q;
    if (clr) begin
      acc_a = '0;
      acc_l = first_l;
    end else if (ld) begin
      acc_a = p.addr;
      acc_l = first_l;
    end else if (inc) begin
      if (lane_q == last_l) begin
        acc_a = cnt_q + 1'b1;
        acc_l = first_l;
      end else if (p.lane_order_select) begin
        acc_l = lane_q - 2'h1;
      end else begin
        acc_l = lane_q + 2'h1;
      end
    end
  end

  // Burst counter and lane sub-counter, sampled on every edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= '0;
      lane_q <= 2'h0;
    end else begin
      cnt_q  <= acc_a;
      lane_q <= acc_l;
    end
  end

  // Lane writes; in narrow modes the low lines carry the lane
  always_ff @(posedge clock) begin
    if (sel && !p.write_n) begin
      for (int i = 0; i < dpr_pkg::LANES; i++) begin
        if (!p.lane_write_mask_n[i]) begin
          case (wid)
            dpr_pkg::DPR_W18: begin
              if (acc_l[0] == i[1]) begin
                mem[acc_a][9*i +: 9] <= p.dq[9*(i%2) +: 9];
              end
            end
            dpr_pkg::DPR_W9: begin
              if (acc_l == i[1:0]) begin
                mem[acc_a][9*i +: 9] <= p.dq[8:0];
              end
            end
            default: begin
              mem[acc_a][9*i +: 9] <= p.dq[9*i +: 9];
            end
          endcase
        end
      end
    end
  end

  // Count of back-to-back readback cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rbph_q <= 2'h0;
    end else if (!rbk) begin
      rbph_q <= 2'h0;
    end else if (rbph_q != 2'h3) begin
      rbph_q <= rbph_q + 2'h1;
    end
  end

  // Counter value as laid out on the data lines
  always_comb begin
    case (wid)
      dpr_pkg::DPR_W18: begin
        rbv = DW'({lane_q[0], cnt_q}) << dpr_pkg::RB_SHIFT_X18;
      end
      dpr_pkg::DPR_W9: begin
        if (int'(rbph_q) < dpr_pkg::RB_X9_HI_CYCLES) begin
          rbv = DW'(cnt_q[AW-1:dpr_pkg::RB_X9_SPLIT]);
        end else begin
          rbv = DW'({lane_q, cnt_q[dpr_pkg::RB_X9_SPLIT-1:0]})
                << dpr_pkg::RB_SHIFT_X9LO;
        end
      end
      default: begin
        rbv = DW'(cnt_q) << dpr_pkg::RB_SHIFT_X36;
      end
    endcase
  end

  // First output stage: controls captured at the edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ra_q  <= '0;
      rl_q  <= 2'h0;
      wid_q <= dpr_pkg::DPR_W36;
      rd_q  <= 1'b0;
      rbk_q <= 1'b0;
      rbv_q <= '0;
    end else begin
      ra_q  <= acc_a;
      rl_q  <= acc_l;
      wid_q <= wid;
      rd_q  <= sel && p.write_n && !rbk;
      rbk_q <= rbk;
      rbv_q <= rbv;
    end
  end

  assign ft_word = rbk_q ? rbv_q : dpr_pkg::lane_pick(mem[ra_q], wid_q, rl_q);
  assign ft_drv  = rd_q || rbk_q;

  // Pipelined output register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pipe_q     <= '0;
      pipe_drv_q <= 1'b0;
    end else begin
      pipe_q     <= ft_word;
      pipe_drv_q <= ft_drv;
    end
  end

  assign drv           = p.output_latency_select ? pipe_drv_q : ft_drv;
  assign p.dev_dq_o    = p.output_latency_select ? pipe_q : ft_word;
  assign p.dev_dq_oe_n = !(drv && !p.out_en_n);

  assign counter_addr = cnt_q;
  assign counter_lane = lane_q;
endmodule
`default_nettype wire

// >>> src/dpr_pkg.sv
// Constants, types and helper functions shared by both ends of one RAM port.
// Assumes the host controller and the port run on one common clock.
//
// Behaviour
// - Inputs clocked, output enable acts asynchronously
// - Deselect floats outputs after next edge, after the second edge when pipelined
// - Strobe held loads address every edge
// - Host strobes only first lane of burst
// - Word spans four x9 or two x18 cycles
// - Host rewrites location after no-operation cycle
// - Output drive follows previous cycle controls
// - Host changes width selects a cycle early
// - Strobe with count uses external address
// - Counter clear allows same cycle access
// - Host disables output enable during writes
// - x9 counter readback extended one cycle
// - Host holds readback controls two/three cycles
// - Latency select adds pipeline output stage
// - Clear beats load, increment, hold
// - Width selects decode x36, x18, x9
// - Lane sub-counter direction follows lane order
package dpr_pkg;
  localparam int ADDR_W          = 15;
  localparam int DATA_W          = 36;
  localparam int LANES           = 4;
  localparam int FIFO_DEPTH      = 16;
  localparam int LAT_FLOW        = 1;
  localparam int LAT_PIPE        = 2;
  localparam int RB_HOLD_WIDE    = 2;
  localparam int RB_HOLD_X9      = 3;
  localparam int RB_X9_HI_CYCLES = 2;
  localparam int RB_SHIFT_X36    = 3;
  localparam int RB_SHIFT_X18    = 2;
  localparam int RB_SHIFT_X9LO   = 1;
  localparam int RB_X9_SPLIT     = 6;
  localparam int CFG_SETTLE      = 1;

  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDLO   = 8'h08;
  localparam logic [7:0] REG_WDHI   = 8'h0c;
  localparam logic [7:0] REG_CMD    = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RDLO   = 8'h18;
  localparam logic [7:0] REG_RDHI   = 8'h1c;
  localparam logic [7:0] CFG_RESET  = 8'h00;

  localparam int CFG_MATCH = 0;
  localparam int CFG_SIZE  = 1;
  localparam int CFG_ORDER = 2;
  localparam int CFG_LAT   = 3;
  localparam int CFG_MASK  = 4;

  typedef enum logic [2:0] {
    DPR_W36 = 3'b001,
    DPR_W18 = 3'b010,
    DPR_W9  = 3'b100
  } dpr_width_e;

  typedef enum logic [1:0] {
    DPR_OP_WRITE = 2'h0,
    DPR_OP_READ  = 2'h1,
    DPR_OP_RBACK = 2'h2,
    DPR_OP_CLEAR = 2'h3
  } dpr_op_e;

  function automatic dpr_width_e width_decode(input logic match, input logic size);
    if (!match) return DPR_W36;
    else if (!size) return DPR_W18;
    else return DPR_W9;
  endfunction

  function automatic logic [2:0] lane_count(input dpr_width_e w);
    case (w)
      DPR_W18: return 3'h2;
      DPR_W9:  return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  // Lane number for the given step of a word
  function automatic logic [1:0] lane_at(input dpr_width_e w, input logic order,
                                         input logic [3:0] step);
    logic [2:0] last;
    last = lane_count(w) - 3'h1;
    if (order) return 2'(last - step[2:0]);
    else return step[1:0];
  endfunction

  function automatic logic [DATA_W-1:0] lane_pick(input logic [DATA_W-1:0] word,
                                                  input dpr_width_e w, input logic [1:0] idx);
    case (w)
      DPR_W18: return {18'h0, idx[0] ? word[35:18] : word[17:0]};
      DPR_W9:  return {27'h0, word[9*idx +: 9]};
      default: return word;
    endcase
  endfunction
endpackage

// >>> src/dpr_port_if.sv
// Pin bundle between the host controller and one RAM port.
// Resolves the shared data lines from the device output enable; flags when both ends drive.
`timescale 1ns/1ps
`default_nettype none
interface dpr_port_if;
  logic                       chip_sel_n;
  logic                       write_n;
  logic                       address_strobe_load_n;
  logic                       count_advance_enable_n;
  logic                       count_clear_n;
  logic                       out_en_n;
  logic                       width_match_select;
  logic                       lane_size_select;
  logic                       lane_order_select;
  logic                       output_latency_select;
  logic [3:0]                 lane_write_mask_n;
  logic [dpr_pkg::ADDR_W-1:0] addr;
  logic [dpr_pkg::DATA_W-1:0] host_dq_o;
  logic                       host_dq_oe_n;
  logic [dpr_pkg::DATA_W-1:0] dev_dq_o;
  logic                       dev_dq_oe_n;
  logic [dpr_pkg::DATA_W-1:0] dq;
  logic                       dq_contention;

  assign dq            = !dev_dq_oe_n ? dev_dq_o : host_dq_o;
  assign dq_contention = !dev_dq_oe_n && !host_dq_oe_n;

  modport dev (
    input  chip_sel_n, write_n, address_strobe_load_n, count_advance_enable_n,
    input  count_clear_n, out_en_n, width_match_select, lane_size_select,
    input  lane_order_select, output_latency_select, lane_write_mask_n, addr, dq,
    output dev_dq_o, dev_dq_oe_n
  );
  modport host (
    output chip_sel_n, write_n, address_strobe_load_n, count_advance_enable_n,
    output count_clear_n, out_en_n, width_match_select, lane_size_select,
    output lane_order_select, output_latency_select, lane_write_mask_n, addr,
    output host_dq_o, host_dq_oe_n,
    input  dq
  );
endinterface
`default_nettype wire

// >>> src/dpr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ps
`default_nettype none
module dpr_fifo #(
  parameter int WIDTH = dpr_pkg::DATA_W,
  parameter int DEPTH = dpr_pkg::FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> src/dpr_host_ctrl.sv
// Host controller for one RAM port, ordered through a small register file.
// Assumes software polls the busy bit; read words queue in a FIFO.
`timescale 1ns/1ps
`default_nettype none
module dpr_host_ctrl (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  dpr_port_if.host         p
);
  localparam int DW = dpr_pkg::DATA_W;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_ARM = 4'b0010, ST_RUN = 4'b0100, ST_PUSH = 4'b1000
  } dpr_hstate_e;

  dpr_hstate_e    st_q, nxt_st;
  dpr_pkg::dpr_op_e op_q;
  logic [7:0]     cfg_q;
  logic [dpr_pkg::ADDR_W-1:0] addr_q;
  logic [DW-1:0]  wd_q, cap_q, f_out;
  logic [3:0]     cyc_q, nxt_cyc, t_end, n_iss, lat, k;
  logic [1:0]     settle_q;
  logic [1:0]     cap_l;
  logic           f_ready, f_valid, pop, go, is_rd, run, act;
  dpr_pkg::dpr_width_e wid;

  assign wid   = dpr_pkg::width_decode(cfg_q[dpr_pkg::CFG_MATCH], cfg_q[dpr_pkg::CFG_SIZE]);
  assign lat   = cfg_q[dpr_pkg::CFG_LAT] ? 4'(dpr_pkg::LAT_PIPE) : 4'(dpr_pkg::LAT_FLOW);
  assign is_rd = op_q == dpr_pkg::DPR_OP_READ || op_q == dpr_pkg::DPR_OP_RBACK;
  assign go    = st_q == ST_IDLE && settle_q == 2'h0 && reg_we && reg_addr == dpr_pkg::REG_CMD;
  assign pop   = reg_re && reg_addr == dpr_pkg::REG_RDHI && f_valid;
  assign k     = cyc_q - lat;
  assign cap_l = dpr_pkg::lane_at(wid, cfg_q[dpr_pkg::CFG_ORDER], k);

  always_comb begin
    case (op_q)
      dpr_pkg::DPR_OP_RBACK: n_iss = (wid == dpr_pkg::DPR_W9) ?
                                     4'(dpr_pkg::RB_HOLD_X9) : 4'(dpr_pkg::RB_HOLD_WIDE);
      dpr_pkg::DPR_OP_CLEAR: n_iss = 4'h1;
      default:               n_iss = 4'(dpr_pkg::lane_count(wid));
    endcase
    t_end = (op_q == dpr_pkg::DPR_OP_WRITE || op_q == dpr_pkg::DPR_OP_CLEAR) ?
            n_iss - 4'h1 : n_iss - 4'h1 + lat;
  end

  always_comb begin
    nxt_st  = st_q;
    nxt_cyc = cyc_q + 4'h1;
    case (st_q)
      ST_IDLE: begin nxt_cyc = 4'h0; if (go) nxt_st = ST_ARM; end
      ST_ARM:  begin nxt_cyc = 4'h0; nxt_st = ST_RUN; end
      ST_RUN:  if (cyc_q == t_end) nxt_st = is_rd ? ST_PUSH : ST_IDLE;
      ST_PUSH: if (f_ready) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end
  assign run = nxt_st == ST_RUN;
  assign act = run && nxt_cyc < n_iss;

  // Sequencer and register file
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE; cyc_q <= 4'h0; op_q <= dpr_pkg::DPR_OP_WRITE;
      cfg_q <= dpr_pkg::CFG_RESET; addr_q <= '0; wd_q <= '0; settle_q <= 2'h0;
    end else begin
      st_q  <= nxt_st;
      cyc_q <= nxt_cyc;
      if (go) op_q <= dpr_pkg::dpr_op_e'(reg_wdata[1:0]);
      if (reg_we && reg_addr == dpr_pkg::REG_CFG && st_q == ST_IDLE) begin
        cfg_q <= reg_wdata[7:0];
        settle_q <= 2'(dpr_pkg::CFG_SETTLE);
      end else if (settle_q != 2'h0) settle_q <= settle_q - 2'h1;
      if (reg_we && reg_addr == dpr_pkg::REG_ADDR) addr_q <= reg_wdata[dpr_pkg::ADDR_W-1:0];
      if (reg_we && reg_addr == dpr_pkg::REG_WDLO) wd_q[31:0] <= reg_wdata;
      if (reg_we && reg_addr == dpr_pkg::REG_WDHI) wd_q[35:32] <= reg_wdata[3:0];
    end
  end

  // Capture returning lanes or counter readback
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cap_q <= '0;
    end else if (st_q == ST_ARM) begin
      cap_q <= '0;
    end else if (st_q == ST_RUN && op_q == dpr_pkg::DPR_OP_READ && cyc_q >= lat && k < n_iss) begin
      case (wid)
        dpr_pkg::DPR_W18: cap_q[18*cap_l[0] +: 18] <= p.dq[17:0];
        dpr_pkg::DPR_W9:  cap_q[9*cap_l +: 9] <= p.dq[8:0];
        default:          cap_q <= p.dq;
      endcase
    end else if (st_q == ST_RUN && op_q == dpr_pkg::DPR_OP_RBACK) begin
      if (wid != dpr_pkg::DPR_W9 && cyc_q == lat) cap_q <= p.dq;
      if (wid == dpr_pkg::DPR_W9 && cyc_q == lat) cap_q[8:0] <= p.dq[8:0];
      if (wid == dpr_pkg::DPR_W9 && cyc_q == lat + 4'h2) cap_q[17:9] <= p.dq[8:0];
    end
  end

  // Port pins, all registered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      p.chip_sel_n <= 1'b1; p.write_n <= 1'b1; p.address_strobe_load_n <= 1'b1;
      p.count_advance_enable_n <= 1'b1; p.count_clear_n <= 1'b1; p.out_en_n <= 1'b1;
      p.host_dq_oe_n <= 1'b1; p.host_dq_o <= '0;
    end else begin
      p.chip_sel_n <= !(act && op_q != dpr_pkg::DPR_OP_CLEAR);
      p.write_n    <= !(act && op_q == dpr_pkg::DPR_OP_WRITE);
      p.address_strobe_load_n <= !(act && (op_q == dpr_pkg::DPR_OP_RBACK ||
                                   (nxt_cyc == 4'h0 && op_q != dpr_pkg::DPR_OP_CLEAR)));
      p.count_advance_enable_n <= !(act && (op_q == dpr_pkg::DPR_OP_WRITE ||
                                    op_q == dpr_pkg::DPR_OP_READ));
      p.count_clear_n <= !(act && op_q == dpr_pkg::DPR_OP_CLEAR);
      p.out_en_n      <= !(run && is_rd);
      p.host_dq_oe_n  <= !(act && op_q == dpr_pkg::DPR_OP_WRITE);
      p.host_dq_o     <= dpr_pkg::lane_pick(wd_q, wid,
                         dpr_pkg::lane_at(wid, cfg_q[dpr_pkg::CFG_ORDER], nxt_cyc));
    end
  end

  assign p.width_match_select    = cfg_q[dpr_pkg::CFG_MATCH];
  assign p.lane_size_select      = cfg_q[dpr_pkg::CFG_SIZE];
  assign p.lane_order_select     = cfg_q[dpr_pkg::CFG_ORDER];
  assign p.output_latency_select = cfg_q[dpr_pkg::CFG_LAT];
  assign p.lane_write_mask_n     = cfg_q[dpr_pkg::CFG_MASK +: 4];
  assign p.addr                  = addr_q;

  dpr_fifo #(.WIDTH(DW), .DEPTH(dpr_pkg::FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .in_valid (st_q == ST_PUSH),
    .in_ready (f_ready),
    .in_data  (cap_q),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data (f_out)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_re) begin
      case (reg_addr)
        dpr_pkg::REG_CFG:    reg_rdata <= {24'h0, cfg_q};
        dpr_pkg::REG_ADDR:   reg_rdata <= 32'(addr_q);
        dpr_pkg::REG_WDLO:   reg_rdata <= wd_q[31:0];
        dpr_pkg::REG_WDHI:   reg_rdata <= {28'h0, wd_q[35:32]};
        dpr_pkg::REG_STATUS: reg_rdata <= {29'h0, !f_ready, f_valid,
                                           st_q != ST_IDLE || settle_q != 2'h0};
        dpr_pkg::REG_RDLO:   reg_rdata <= f_out[31:0];
        dpr_pkg::REG_RDHI:   reg_rdata <= {28'h0, f_out[35:32]};
        default:             reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dpr_link_checker.sv
// Concurrent checks on the pins between host controller and RAM port.
// Assumes one clock domain; fed from the pin bundle by name in the bench.
`timescale 1ns/1ps
`default_nettype none
module dpr_link_checker #(
  parameter int AW = dpr_pkg::ADDR_W
) (
  input wire logic          clock,
  input wire logic          nrst,
  input wire logic          chip_sel_n,
  input wire logic          write_n,
  input wire logic          address_strobe_load_n,
  input wire logic          count_advance_enable_n,
  input wire logic          count_clear_n,
  input wire logic          out_en_n,
  input wire logic          width_match_select,
  input wire logic          lane_size_select,
  input wire logic          lane_order_select,
  input wire logic          output_latency_select,
  input wire logic [AW-1:0] addr,
  input wire logic          dev_dq_oe_n,
  input wire logic          dq_contention,
  input wire logic [AW-1:0] counter_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire logic inc = count_clear_n && address_strobe_load_n && !count_advance_enable_n;
  wire logic ld  = count_clear_n && !address_strobe_load_n && !count_advance_enable_n;
  sequence s_inc_x9;
    inc && width_match_select && lane_size_select;
  endsequence
  sequence s_inc_x18;
    inc && width_match_select && !lane_size_select;
  endsequence
  sequence s_read_ft;
    !chip_sel_n && write_n && !output_latency_select;
  endsequence
  sequence s_read_pl;
    !chip_sel_n && write_n && output_latency_select;
  endsequence

  a_clear_wins: assert property (!count_clear_n |=> counter_addr == '0)
    else $error("counter not cleared");
  a_load_ext: assert property (
    count_clear_n && !address_strobe_load_n && !count_advance_enable_n
    |=> counter_addr == $past(addr)) else $error("external address not loaded");
  a_hold_addr: assert property (
    count_clear_n && count_advance_enable_n |=> $stable(counter_addr))
    else $error("counter moved while held");
  a_inc_wrap: assert property (
    inc && !width_match_select |=> counter_addr == AW'($past(counter_addr) + 1'b1))
    else $error("wide increment wrong");
  a_x9_word: assert property (
    (ld && width_match_select && lane_size_select) ##1 s_inc_x9 [*3]
    |=> counter_addr == $past(addr, 4)) else $error("byte lanes per word wrong");
  a_x18_word: assert property (
    (ld && width_match_select && !lane_size_select) ##1 s_inc_x18
    |=> counter_addr == $past(addr, 2)) else $error("word lanes per word wrong");
  a_oe_async: assert property (out_en_n |-> dev_dq_oe_n)
    else $error("driving with output enable off");
  a_desel_flow: assert property (
    chip_sel_n && !output_latency_select |=> dev_dq_oe_n) else $error("no float");
  a_desel_pipe: assert property (
    chip_sel_n && output_latency_select |=> ##1 dev_dq_oe_n) else $error("no float");
  a_write_quiet: assert property (
    !chip_sel_n && !write_n && !output_latency_select |=> dev_dq_oe_n)
    else $error("drive after write");
  a_read_flow: assert property (s_read_ft ##1 !out_en_n |-> !dev_dq_oe_n)
    else $error("flow-through read not driven");
  a_read_pipe: assert property (s_read_pl ##2 !out_en_n |-> !dev_dq_oe_n)
    else $error("pipelined read not driven");
  a_no_clash: assert property (!dq_contention)
    else $error("both ends drive data");
  a_cfg_idle: assert property (
    $changed({width_match_select, lane_size_select, lane_order_select}) |-> chip_sel_n)
    else $error("width changed during access");
endmodule
`default_nettype wire

// >>> testbench/sync_dual_port_ram_port_tb.sv
// Self-checking bench: host controller and RAM port joined by the pin bundle.
// Drives the register port; a watcher checks read data against queued notes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module sync_dual_port_ram_port_tb;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic        re_q = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] last;
  logic [14:0] counter_addr;
  logic [1:0]  counter_lane;
  logic [32:0] notes [$];
  logic [35:0] fw [17];
  logic [2:0]  mode_tab [6] = '{3'b000, 3'b001, 3'b101, 3'b011, 3'b111, 3'b100};
  int          n_mismatch = 0;
  int          comparisons = 0;

  dpr_port_if dpr_port_if_i ();
  dpr_ram_port dpr_ram_port_i (.clock(clock), .nrst(nrst), .p(dpr_port_if_i.dev),
    .counter_addr(counter_addr), .counter_lane(counter_lane));
  dpr_host_ctrl dpr_host_ctrl_i (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .p(dpr_port_if_i.host));
  dpr_link_checker #(.AW(dpr_pkg::ADDR_W)) dpr_link_checker_i (.clock(clock), .nrst(nrst),
    .chip_sel_n(dpr_port_if_i.chip_sel_n), .write_n(dpr_port_if_i.write_n),
    .address_strobe_load_n(dpr_port_if_i.address_strobe_load_n),
    .count_advance_enable_n(dpr_port_if_i.count_advance_enable_n),
    .count_clear_n(dpr_port_if_i.count_clear_n), .out_en_n(dpr_port_if_i.out_en_n),
    .width_match_select(dpr_port_if_i.width_match_select),
    .lane_size_select(dpr_port_if_i.lane_size_select),
    .lane_order_select(dpr_port_if_i.lane_order_select),
    .output_latency_select(dpr_port_if_i.output_latency_select),
    .addr(dpr_port_if_i.addr), .dev_dq_oe_n(dpr_port_if_i.dev_dq_oe_n),
    .dq_contention(dpr_port_if_i.dq_contention), .counter_addr(counter_addr));

  initial begin
    forever #5 clock = ~clock;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (re_q && notes.size() > 0) begin
      if (notes[0][32]) `CHK(reg_rdata, notes[0][31:0])
      void'(notes.pop_front());
    end
    re_q <= reg_re;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic c);
    reg_addr <= a;
    reg_re <= 1'b1;
    notes.push_back({c, e});
    @(posedge clock);
    reg_re <= 1'b0;
    #1 last = reg_rdata;
    @(posedge clock);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 100; i++) begin
      rd(dpr_pkg::REG_STATUS, 32'h0, 1'b0);
      if (last[0] === 1'b0) break;
    end
    if (i == 100) begin
      n_mismatch++;
      $display("[FAIL] %0t busy never cleared", $time);
      give_verdict();
    end
  endtask

  task automatic issue(input logic [1:0] cmd, input logic [14:0] a, input logic [35:0] d);
    wr(dpr_pkg::REG_ADDR, {17'h0, a});
    wr(dpr_pkg::REG_WDLO, d[31:0]);
    wr(dpr_pkg::REG_WDHI, {28'h0, d[35:32]});
    wr(dpr_pkg::REG_CMD, {30'h0, cmd});
  endtask

  task automatic op(input logic [1:0] cmd, input logic [14:0] a, input logic [35:0] d);
    issue(cmd, a, d);
    wait_idle();
  endtask

  task automatic pop(input logic [35:0] e);
    rd(dpr_pkg::REG_RDLO, e[31:0], 1'b1);
    rd(dpr_pkg::REG_RDHI, {28'h0, e[35:32]}, 1'b1);
  endtask

  initial begin
    logic [35:0] w;
    logic [35:0] top;
    logic [14:0] a;
    int k;
    void'($urandom(32'ha39b1306));
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(dpr_pkg::REG_CFG, {24'h0, dpr_pkg::CFG_RESET}, 1'b1);
    rd(dpr_pkg::REG_STATUS, 32'h0, 1'b1);
    rd(8'h20, 32'h0, 1'b1);
    $display("test reset_values done");
    // Every width and order, flow-through then pipelined, top address included
    for (k = 0; k < 12; k++) begin
      wr(dpr_pkg::REG_CFG, {28'h0, 1'(k / 6), mode_tab[k % 6]});
      if (k > 0) begin
        op(dpr_pkg::DPR_OP_READ, 15'h7fff, 36'h0);
        pop(top);
      end
      a = {1'b0, 14'($urandom())};
      w = {4'($urandom()), 32'($urandom())};
      top = ~w;
      op(dpr_pkg::DPR_OP_WRITE, a, w);
      op(dpr_pkg::DPR_OP_WRITE, 15'h7fff, top);
      op(dpr_pkg::DPR_OP_READ, a, 36'h0);
      pop(w);
    end
    $display("test width_modes done");
    // Fill the read buffer until the host stalls, then drain it
    for (k = 0; k < 17; k++) begin
      fw[k] = {4'($urandom()), 32'($urandom())};
      op(dpr_pkg::DPR_OP_WRITE, 15'(k), fw[k]);
    end
    for (k = 0; k < 16; k++) op(dpr_pkg::DPR_OP_READ, 15'(k), 36'h0);
    rd(dpr_pkg::REG_STATUS, 32'h6, 1'b1);
    issue(dpr_pkg::DPR_OP_READ, 15'h10, 36'h0);
    rd(dpr_pkg::REG_STATUS, 32'h7, 1'b1);
    pop(fw[0]);
    wait_idle();
    for (k = 1; k < 17; k++) pop(fw[k]);
    rd(dpr_pkg::REG_STATUS, 32'h0, 1'b1);
    $display("test read_buffer done");
    // Load the counter, read it back wide and in byte lanes, then clear it
    op(dpr_pkg::DPR_OP_WRITE, 15'h1234, 36'h0);
    op(dpr_pkg::DPR_OP_RBACK, 15'h0, 36'h0);
    pop(36'h91a0);
    wr(dpr_pkg::REG_CFG, 32'h3);
    op(dpr_pkg::DPR_OP_RBACK, 15'h0, 36'h0);
    pop(36'hd048);
    op(dpr_pkg::DPR_OP_CLEAR, 15'h1234, 36'h0);
    `CHK(counter_addr, 15'h0)
    $display("test counter_clear done");
    give_verdict();
  end
endmodule
`default_nettype wire
